// ### rtl/gio_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the per-pin general-purpose I/O logic.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef GIO_DEFINES_SVH
`define GIO_DEFINES_SVH

`define GIO_ADDR_W 12
`define GIO_CTRL_OFS 12'h000
`define GIO_STAT_OFS 12'h004

`define GIO_CTRL_W 15
`define GIO_F_MODE_LO 0
`define GIO_F_IN_REG 3
`define GIO_F_OUT_REG 4
`define GIO_F_IN_FALL 5
`define GIO_F_OUT_FALL 6
`define GIO_F_OE_FALL 7
`define GIO_F_OE_REG 8
`define GIO_F_INVERT 9
`define GIO_F_DOUBLE_EDGE_IO_IN 10
`define GIO_F_DOUBLE_EDGE_IO_OUT 11
`define GIO_F_RESYNC 12
`define GIO_F_PULL_DOWN 13
`define GIO_F_DIFF_SE 14

`define GIO_S_PAD 0
`define GIO_S_PAD_OE 1
`define GIO_S_RISE 2
`define GIO_S_FALL 3
`define GIO_S_CONFIG 4

`define GIO_CTRL_RST 15'h0000
`define GIO_CLK_HZ 10000000
`define GIO_APB_WAIT 1

`endif

// ### rtl/gio_io_logic.sv
// Per-pin I/O logic between core fabric and one pad, with APB control.
// Assumes core clocks arrive as levels synchronous to MCLK; their edges
// are found by sampling, so they must run well below MCLK / 2.
//
// Design decisions made here: the register addresses and the APB slave port.
`default_nettype none
`include "gio_defines.svh"

////////////////////////////////////////////////////////////////////////
// Function
// R1: Input mode enables only pad-to-core path, passed through or registered.
// R2: Registered input captures on chosen edge of the input register clock.
// R3: Alternate input is never registered; pad value goes straight out.
// R4: Double-edge input captures pad on both input clock edges separately.
// R5: Output mode enables only core-to-pad path, registered on chosen edge.
// R6: An option inverts the output register value before the pad.
// R7: Double-edge output holds both edge values, multiplexed onto the pad.
// R8: Bidirectional: input clock for input, output clock for output and enable.
// R9: Bidirectional: each register has its own rising or falling edge choice.
// R10: Bidirectional: input and output paths registered independently.
// R11: Clock-output mode drives pad from core clock network, not data.
// R12: Alternate mode sends pad signal straight to another interface block.
// R13: Output-enable register decides whether the pad buffer drives.
// R14: Input register captures pad signal before it reaches the core.
// R15: Output register captures core signal before the pad buffer.
// R16: During configuration ordinary pins held in weak pull-up.
// R17: During configuration single-ended differential pins tri-stated, no pulls.
// R18: Unused pins in user mode tri-stated, pull-up default, pull-down option.
// R19: Weak pull-up pin does not glitch entering user mode.
// R20: Double-edge input: first output rising sample, second falling sample.
// R21: Double-edge output: first input rising launch, second falling launch.
// R22: Resync mode delays falling sample half cycle to align with rising.
// R23: Output enable high drives the pad; low tri-states it.
module gio_io_logic
  import gio_pkg::*;
#(
  parameter int ADDR_W = `GIO_ADDR_W
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CONFIGURING,
  input wire logic INPUT_REGISTER_CLOCK,
  input wire logic OUTPUT_REGISTER_CLOCK,
  input wire logic CORE_CLOCK_NET,
  input wire logic RISE_LAUNCH_FROM_CORE,
  input wire logic FALL_LAUNCH_FROM_CORE,
  input wire logic OE_FROM_CORE,
  output logic RISE_SAMPLE_TO_CORE,
  output logic FALL_SAMPLE_TO_CORE,
  output logic ALTERNATE_INPUT,
  input wire logic PAD_I,
  output logic PAD_O,
  output logic PAD_OE,
  output logic PAD_PULL_UP,
  output logic PAD_PULL_DOWN
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Picks the rising or the falling event of a sampled clock
  function automatic logic edge_hit(input logic rise, input logic fall,
                                    input logic sel_fall);
    edge_hit = sel_fall ? fall : rise;
  endfunction

  function automatic logic [31:0] ctrl_word(input gio_ctrl_t c);
    ctrl_word = {{(32 - `GIO_CTRL_W){1'b0}}, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  gio_state_t state_ff;
  gio_state_t nxt_state;

  logic in_rise;
  logic in_fall;
  logic out_rise;
  logic out_fall;
  logic double_edge_io_in_ok;
  logic double_edge_io_out_ok;
  logic in_active;
  logic out_active;
  logic out_value;
  logic apb_setup;
  logic apb_write;
  logic [31:0] status_word;

  assign in_rise = INPUT_REGISTER_CLOCK & ~state_ff.input_register_clock_q;
  assign in_fall = ~INPUT_REGISTER_CLOCK & state_ff.input_register_clock_q;
  assign out_rise = OUTPUT_REGISTER_CLOCK & ~state_ff.output_register_clock_q;
  assign out_fall = ~OUTPUT_REGISTER_CLOCK & state_ff.output_register_clock_q;

  // Single-ended differential pins have no double-edge registers
  assign double_edge_io_in_ok = state_ff.ctrl.double_edge_io_in & ~state_ff.ctrl.diff_se;
  assign double_edge_io_out_ok = state_ff.ctrl.double_edge_io_out & ~state_ff.ctrl.diff_se;

  assign apb_setup = PSEL & ~PENABLE;
  assign apb_write = PSEL & PENABLE & PWRITE;

  ////////////////////////////////////////////////////////////////////////
  // Path enables per mode

  always_comb begin
    in_active = 1'b0;
    out_active = 1'b0;
    unique case (state_ff.ctrl.mode)
      GIO_INPUT: begin
        in_active = 1'b1; // R1
      end
      GIO_OUTPUT: begin
        out_active = 1'b1; // R5
      end
      GIO_BIDIR: begin
        in_active = 1'b1; // R8
        out_active = 1'b1; // R8
      end
      GIO_UNUSED, GIO_CLKOUT, GIO_ALT: begin
        in_active = 1'b0;
      end
      default: begin
        in_active = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_state = state_ff;
    nxt_state.input_register_clock_q = INPUT_REGISTER_CLOCK;
    nxt_state.output_register_clock_q = OUTPUT_REGISTER_CLOCK;

    // Input capture
    if (double_edge_io_in_ok) begin
      if (in_rise) begin
        nxt_state.in_rise_q = PAD_I; // R4
        nxt_state.in_fall_sync_q = state_ff.in_fall_q; // R22
      end
      if (in_fall) begin
        nxt_state.in_fall_q = PAD_I; // R4
      end
    end else if (edge_hit(in_rise, in_fall, state_ff.ctrl.in_fall)) begin
      nxt_state.in_rise_q = PAD_I; // R2 R9 R14
    end

    // Output and enable capture on the output clock
    if (double_edge_io_out_ok) begin
      if (out_rise) begin
        nxt_state.out_rise_q = RISE_LAUNCH_FROM_CORE; // R7 R21
      end
      if (out_fall) begin
        nxt_state.out_fall_q = FALL_LAUNCH_FROM_CORE; // R7 R21
      end
    end else if (edge_hit(out_rise, out_fall, state_ff.ctrl.out_fall)) begin
      nxt_state.out_rise_q = RISE_LAUNCH_FROM_CORE; // R5 R9 R15
    end
    if (edge_hit(out_rise, out_fall, state_ff.ctrl.oe_fall)) begin
      nxt_state.oe_q = OE_FROM_CORE; // R8 R9 R13
    end

    // Weak pulls, held in flops so both phases agree at the change-over
    if (CONFIGURING) begin
      nxt_state.pull_up_q = ~state_ff.ctrl.diff_se; // R16 R17
      nxt_state.pull_down_q = 1'b0; // R16 R17
    end else begin
      nxt_state.pull_up_q = ~state_ff.ctrl.pull_down; // R18 R19
      nxt_state.pull_down_q = state_ff.ctrl.pull_down & ~state_ff.ctrl.diff_se; // R18
    end

    // APB: read data latched in setup, write taken in access
    if (apb_setup) begin
      nxt_state.pslverr_q = 1'b0;
      if (PADDR == ADDR_W'(`GIO_CTRL_OFS)) begin
        nxt_state.prdata_q = ctrl_word(state_ff.ctrl);
      end else if (PADDR == ADDR_W'(`GIO_STAT_OFS)) begin
        nxt_state.prdata_q = status_word;
        nxt_state.pslverr_q = PWRITE;
      end else begin
        nxt_state.prdata_q = 32'h0000_0000;
        nxt_state.pslverr_q = 1'b1;
      end
    end
    if (apb_write && PADDR == ADDR_W'(`GIO_CTRL_OFS)) begin
      nxt_state.ctrl = gio_ctrl_t'(PWDATA[`GIO_CTRL_W-1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= '0;
      state_ff.ctrl <= gio_ctrl_t'(`GIO_CTRL_RST);
      state_ff.pull_up_q <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core-side input data

  always_comb begin
    RISE_SAMPLE_TO_CORE = 1'b0;
    FALL_SAMPLE_TO_CORE = 1'b0;
    if (in_active) begin
      if (double_edge_io_in_ok) begin
        RISE_SAMPLE_TO_CORE = state_ff.in_rise_q; // R20
        FALL_SAMPLE_TO_CORE = state_ff.ctrl.resync ?
                              state_ff.in_fall_sync_q : state_ff.in_fall_q; // R20 R22
      end else if (state_ff.ctrl.in_reg) begin
        RISE_SAMPLE_TO_CORE = state_ff.in_rise_q; // R1 R10 R14
      end else begin
        RISE_SAMPLE_TO_CORE = PAD_I; // R1 R10
      end
    end
  end

  // Alternate function path bypasses every register
  assign ALTERNATE_INPUT = (state_ff.ctrl.mode == GIO_ALT) ? PAD_I : 1'b0; // R3 R12

  ////////////////////////////////////////////////////////////////////////
  // Pad-side output data and enable

  always_comb begin
    if (double_edge_io_out_ok) begin
      // High phase shows rising launch, low phase the falling one
      out_value = (state_ff.output_register_clock_q ? state_ff.out_rise_q : state_ff.out_fall_q)
                  ^ state_ff.ctrl.invert; // R6 R7
    end else if (state_ff.ctrl.out_reg) begin
      out_value = state_ff.out_rise_q ^ state_ff.ctrl.invert; // R6 R10 R15
    end else begin
      out_value = RISE_LAUNCH_FROM_CORE; // R5 R10
    end
  end

  always_comb begin
    PAD_O = 1'b0;
    PAD_OE = 1'b0;
    if (!CONFIGURING) begin
      if (state_ff.ctrl.mode == GIO_CLKOUT) begin
        PAD_O = CORE_CLOCK_NET; // R11
        PAD_OE = 1'b1; // R11 R23
      end else if (out_active) begin
        PAD_O = out_value;
        if (state_ff.ctrl.mode == GIO_BIDIR) begin
          PAD_OE = state_ff.ctrl.oe_reg ? state_ff.oe_q : OE_FROM_CORE; // R13 R23
        end else begin
          PAD_OE = 1'b1; // R5 R23
        end
      end
    end
  end

  assign PAD_PULL_UP = state_ff.pull_up_q;
  assign PAD_PULL_DOWN = state_ff.pull_down_q;

  ////////////////////////////////////////////////////////////////////////
  // Status and bus answers

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`GIO_S_PAD] = PAD_I;
    status_word[`GIO_S_PAD_OE] = PAD_OE;
    status_word[`GIO_S_RISE] = RISE_SAMPLE_TO_CORE;
    status_word[`GIO_S_FALL] = FALL_SAMPLE_TO_CORE;
    status_word[`GIO_S_CONFIG] = CONFIGURING;
  end

  // One wait-free access phase: data latched in setup
  assign PREADY = 1'b1;
  assign PRDATA = state_ff.prdata_q;
  assign PSLVERR = PSEL & PENABLE & state_ff.pslverr_q;

endmodule

`default_nettype wire

// ### rtl/gio_pkg.sv
// Types for the per-pin general-purpose I/O logic.
// Assumes gio_defines.svh for widths.
`default_nettype none
`include "gio_defines.svh"

package gio_pkg;

  typedef enum logic [2:0] {
    GIO_UNUSED,
    GIO_INPUT,
    GIO_OUTPUT,
    GIO_BIDIR,
    GIO_CLKOUT,
    GIO_ALT
  } gio_mode_t;

  // Field order matches the bit positions of the control word
  typedef struct packed {
    logic diff_se;
    logic pull_down;
    logic resync;
    logic double_edge_io_out;
    logic double_edge_io_in;
    logic invert;
    logic oe_reg;
    logic oe_fall;
    logic out_fall;
    logic in_fall;
    logic out_reg;
    logic in_reg;
    gio_mode_t mode;
  } gio_ctrl_t;

  typedef struct packed {
    gio_ctrl_t ctrl;
    logic input_register_clock_q;
    logic output_register_clock_q;
    logic in_rise_q;
    logic in_fall_q;
    logic in_fall_sync_q;
    logic out_rise_q;
    logic out_fall_q;
    logic oe_q;
    logic pull_up_q;
    logic pull_down_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
  } gio_state_t;

endpackage

`default_nettype wire

// ### test/gio_far_model.sv
// Far side: core clocks and the pad wire.
// Assumes MCLK and NRST shared with the pin logic.
`default_nettype none
module gio_far_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pad_o,
  input wire logic pad_oe,
  input wire logic pull_up,
  input wire logic pull_dn,
  input wire logic ext_en,
  input wire logic ext_val,
  input wire logic follow,
  output logic pad_i,
  output logic in_clk,
  output logic out_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
  assign in_clk = cnt_ff[2];
  assign out_clk = cnt_ff[2] ^ cnt_ff[1];
  // Floating pad toggles
  always_comb begin
    if (pad_oe) begin
      pad_i = pad_o;
    end else if (follow) begin
      pad_i = in_clk;
    end else if (ext_en) begin
      pad_i = ext_val;
    end else if (pull_up || pull_dn) begin
      pad_i = pull_up;
    end else begin
      pad_i = cnt_ff[0];
    end
  end
endmodule
`default_nettype wire

// ### test/gio_io_logic_asserts.sv
// Checker on the pin logic top ports.
// Assumes CTRL is mirrored from observed APB writes.
`default_nettype none
`include "gio_defines.svh"
module gio_io_logic_asserts #(
  parameter int ADDR_W = `GIO_ADDR_W
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic CONFIGURING,
  input wire logic INPUT_REGISTER_CLOCK,
  input wire logic CORE_CLOCK_NET,
  input wire logic OE_FROM_CORE,
  input wire logic RISE_SAMPLE_TO_CORE,
  input wire logic ALTERNATE_INPUT,
  input wire logic PAD_I,
  input wire logic PAD_O,
  input wire logic PAD_OE,
  input wire logic PAD_PULL_UP,
  input wire logic PAD_PULL_DOWN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] c_ff;
  logic wr;
  assign wr = PSEL && PENABLE && PWRITE && PADDR == `GIO_CTRL_OFS;
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      c_ff <= 15'h0;
    end else if (wr) begin
      c_ff <= PWDATA[14:0];
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);
  property p_cfg_off; CONFIGURING |-> !PAD_OE && !PAD_O; endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("pad driven");
  property p_cfg_pull; CONFIGURING && !wr |=> PAD_PULL_UP == !c_ff[14] && !PAD_PULL_DOWN;
  endproperty
  a_cfg_pull: assert property (p_cfg_pull) else $error("config pull");
  property p_usr_pull; !CONFIGURING && !wr |=> PAD_PULL_UP == !c_ff[13] &&
    PAD_PULL_DOWN == (c_ff[13] && !c_ff[14]); endproperty
  a_usr_pull: assert property (p_usr_pull) else $error("user pull");
  property p_alt; ALTERNATE_INPUT == (c_ff[2:0] == 3'h5 && PAD_I); endproperty
  a_alt: assert property (p_alt) else $error("alt path");
  property p_clk; c_ff[2:0] == 3'h4 && !CONFIGURING |-> PAD_OE && PAD_O == CORE_CLOCK_NET;
  endproperty
  a_clk: assert property (p_clk) else $error("clock out");
  property p_pass; c_ff[2:0] == 3'h1 && !c_ff[3] && !c_ff[10] |-> RISE_SAMPLE_TO_CORE == PAD_I;
  endproperty
  a_pass: assert property (p_pass) else $error("in pass");
  property p_rise; c_ff[2:0] == 3'h1 && c_ff[3] && !c_ff[5] && !c_ff[10] && !wr &&
    $rose(INPUT_REGISTER_CLOCK) |=> RISE_SAMPLE_TO_CORE == $past(PAD_I); endproperty
  a_rise: assert property (p_rise) else $error("in capture");
  property p_oe; c_ff[2:0] == 3'h3 && !c_ff[8] && !CONFIGURING |-> PAD_OE == OE_FROM_CORE;
  endproperty
  a_oe: assert property (p_oe) else $error("bidir enable");
  property p_keep_up; !c_ff[13] && !c_ff[14] && !wr |=> PAD_PULL_UP; endproperty
  a_keep_up: assert property (p_keep_up) else $error("pull-up dropped");
endmodule
bind gio_io_logic gio_io_logic_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .CONFIGURING(CONFIGURING), .INPUT_REGISTER_CLOCK(INPUT_REGISTER_CLOCK),
  .CORE_CLOCK_NET(CORE_CLOCK_NET), .OE_FROM_CORE(OE_FROM_CORE),
  .RISE_SAMPLE_TO_CORE(RISE_SAMPLE_TO_CORE), .ALTERNATE_INPUT(ALTERNATE_INPUT), .PAD_I(PAD_I),
  .PAD_O(PAD_O), .PAD_OE(PAD_OE), .PAD_PULL_UP(PAD_PULL_UP), .PAD_PULL_DOWN(PAD_PULL_DOWN));
`default_nettype wire

// ### test/gio_io_logic_test.sv
// Bench for the pin logic.
// Assumes model and checker compiled first.
`default_nettype none
`include "gio_defines.svh"
module gio_io_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, nrst, psel, penable, pwrite, cfg, cclk, rl, fl, oe, ee, ev, fo;
  logic pready, e, rs, fs, alternate_input, pi, po, poe, pu, pd, ic, oc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic err;
  int n_fail = 0;
  int checks_done = 0;
  always #50 mclk = ~mclk;
  gio_io_logic gio_io_logic_inst (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(e), .CONFIGURING(cfg), .INPUT_REGISTER_CLOCK(ic), .OUTPUT_REGISTER_CLOCK(oc),
    .CORE_CLOCK_NET(cclk), .RISE_LAUNCH_FROM_CORE(rl), .FALL_LAUNCH_FROM_CORE(fl),
    .OE_FROM_CORE(oe), .RISE_SAMPLE_TO_CORE(rs), .FALL_SAMPLE_TO_CORE(fs),
    .ALTERNATE_INPUT(alternate_input), .PAD_I(pi), .PAD_O(po), .PAD_OE(poe), .PAD_PULL_UP(pu),
    .PAD_PULL_DOWN(pd));
  gio_far_model gio_far_model_inst (.mclk(mclk), .nrst(nrst), .pad_o(po), .pad_oe(poe),
    .pull_up(pu), .pull_dn(pd), .ext_en(ee), .ext_val(ev), .follow(fo), .pad_i(pi),
    .in_clk(ic), .out_clk(oc));
  //////////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      n_fail++;
      results();
    end else begin
      q = prdata;
      err = e;
    end
  endtask
  task automatic wc(input logic [31:0] d);
    apb(1'h1, `GIO_CTRL_OFS, d);
    wt(3);
  endtask
  task automatic t_regs();
    apb(1'h0, `GIO_CTRL_OFS, 32'h0);
    cmp(q, 32'h0);
    cmp(err, 1'h0);
    apb(1'h1, `GIO_CTRL_OFS, 32'hffffffff);
    apb(1'h0, `GIO_CTRL_OFS, 32'h0);
    cmp(q, 32'h7fff);
    apb(1'h1, `GIO_STAT_OFS, 32'h1);
    cmp(err, 1'h1);
    apb(1'h0, 12'h008, 32'h0);
    cmp(q, 32'h0);
    cmp(err, 1'h1);
  endtask
  task automatic t_cfg();
    @(posedge mclk);
    cfg <= 1'h1;
    wc(32'h2);
    cmp({poe, po, pu, pd}, 4'h2);
    wc(32'h4002);
    cmp({poe, pu, pd}, 3'h0);
    wc(32'h0);
    @(posedge mclk);
    cfg <= 1'h0;
    repeat (3) begin
      wt(1);
      cmp(pu, 1'h1);
    end
    wc(32'h2000);
    cmp({poe, pu, pd}, 3'h1);
  endtask
  task automatic t_in();
    @(posedge mclk);
    fo <= 1'h1;
    wc(32'h1);
    wc(32'h9);
    wt(12);
    cmp(rs, 1'h1);
    wc(32'h29);
    wt(12);
    cmp(rs, 1'h0);
    wc(32'h401);
    wt(12);
    cmp({rs, fs}, 2'h2);
    @(posedge mclk);
    fo <= 1'h0;
  endtask
  // Steps one cycle at a time until the input clock shows level v
  task automatic wait_ic(input logic v);
    int n;
    n = 0;
    do begin
      wt(1);
      n++;
    end while (ic !== v && n < 16);
    if (ic !== v) begin
      n_fail++;
      results();
    end
  endtask
  task automatic t_resync();
    @(posedge mclk);
    fo <= 1'h0;
    ee <= 1'h1;
    ev <= 1'h1;
    wc(32'h1401);
    wt(12);
    cmp({rs, fs}, 2'h3);
    wait_ic(1'h1);
    @(posedge mclk);
    ev <= 1'h0;
    wait_ic(1'h0);
    wt(2);
    cmp(fs, 1'h1);
    wt(4);
    cmp({rs, fs}, 2'h0);
  endtask
  task automatic t_out();
    logic g;
    @(posedge mclk);
    rl <= 1'h1;
    wc(32'h2);
    cmp({poe, po}, 2'h3);
    wc(32'h212);
    wt(12);
    cmp({poe, po}, 2'h2);
    wc(32'h802);
    wt(12);
    repeat (16) begin
      g = oc;
      wt(1);
      cmp(po, g);
    end
  endtask
  task automatic t_bidir();
    @(posedge mclk);
    oe <= 1'h1;
    wc(32'h3);
    cmp({poe, po, rs}, 3'h7);
    @(posedge mclk);
    oe <= 1'h0;
    ee <= 1'h1;
    wt(2);
    cmp({poe, rs}, 2'h0);
  endtask
  task automatic t_clk_alt();
    wc(32'h4);
    @(posedge mclk);
    cclk <= 1'h1;
    wt(1);
    cmp({poe, po}, 2'h3);
    @(posedge mclk);
    cclk <= 1'h0;
    ev <= 1'h1;
    wt(1);
    cmp(po, 1'h0);
    apb(1'h0, `GIO_STAT_OFS, 32'h0);
    cmp(q, 32'h2);
    wc(32'h5);
    cmp({alternate_input, rs}, 2'h2);
  endtask
  initial begin
    {mclk, nrst, psel, penable, pwrite, cfg, cclk, rl, fl, oe, ee, ev, fo} = 13'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    nrst <= 1'h1;
    t_regs();
    t_cfg();
    t_in();
    t_resync();
    t_out();
    t_bidir();
    t_clk_alt();
    results();
  end
endmodule
`default_nettype wire
